// File: rtl/srl_latch_top.v
// Function
// RULE1 - latch holds state, inputs active high
// RULE2 - set/reset from soft, cmp1, cmp2, pin, pulse
// RULE3 - both set and reset gives reset
// RULE4 - soft set/reset bits self clear
// RULE5 - comparator may sync to timer clock
// RULE6 - three-bit field selects divide 4..512
// RULE7 - pulse drives set/reset only when enabled
// RULE8 - firmware avoids one source on both inputs
// RULE9 - separate true/inverted pin enables, both allowed
// RULE10 - firmware clears pin direction bit first
// RULE11 - reset leaves latch state undefined
// RULE12 - pulse one clock wide, once per period
// RULE13 - latch enable gates whole latch function
// RULE14 - soft bits write-one, one cycle, read zero
// RULE15 - divider free-running counter, bit selected
//
// Decided for this implementation: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "srl_regs.vh"

module srl_latch_top (
  input wire sys_clk_in,
  input wire rst_in,
  // avalon-mm slave
  input wire [3:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  // sources, asynchronous to sys_clk_in
  input wire cmp1_in,
  input wire cmp2_in,
  input wire ext_latch_input_in,
  input wire timer_clk_in,
  // latch pins
  output reg true_out_pin_out,
  output reg true_out_oe_out,
  output reg inverted_out_pin_out,
  output reg inverted_out_oe_out
);

  // ========================================================
  // input synchronisers
  reg [1:0] cmp1_sync_reg;
  reg [1:0] cmp2_sync_reg;
  reg [1:0] ext_sync_reg;
  // third timer flop only remembers the last level, for the edge
  reg [2:0] tmr_sync_reg;

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      cmp1_sync_reg <= 2'h0;
      cmp2_sync_reg <= 2'h0;
      ext_sync_reg <= 2'h0;
      tmr_sync_reg <= 3'h0;
    end else begin
      cmp1_sync_reg <= {cmp1_sync_reg[0], cmp1_in};
      cmp2_sync_reg <= {cmp2_sync_reg[0], cmp2_in};
      ext_sync_reg <= {ext_sync_reg[0], ext_latch_input_in};
      tmr_sync_reg <= {tmr_sync_reg[1:0], timer_clk_in};
    end
  end

  wire cmp1_lvl;
  wire cmp2_lvl;
  wire ext_lvl;
  wire tmr_rise;

  assign cmp1_lvl = cmp1_sync_reg[1];
  assign cmp2_lvl = cmp2_sync_reg[1];
  assign ext_lvl = ext_sync_reg[1];
  assign tmr_rise = tmr_sync_reg[1] & ~tmr_sync_reg[2];

  // ========================================================
  // registers
  reg latch_enable_reg;
  reg [2:0] periodic_pulse_divider_reg;
  reg true_out_enable_reg;
  reg inverted_out_enable_reg;
  reg [7:0] latch_ctrl_b_reg;
  reg [1:0] latch_ctrl_c_reg;
  reg soft_set_pulse_reg;
  reg soft_reset_pulse_reg;
  wire [7:0] ctrl_a_rst;

  wire pulse_set_enable;
  wire pulse_reset_enable;

  assign pulse_set_enable = latch_ctrl_b_reg[`SRL_B_SET_PULSE];
  assign pulse_reset_enable = latch_ctrl_b_reg[`SRL_B_RST_PULSE];

  // reset image of latch_ctrl_a, cut into its fields on reset
  assign ctrl_a_rst = `SRL_RST_CTRL_A;

  // ========================================================
  // comparator sampling on the timer clock
  reg cmp1_synced_out_reg;
  reg cmp2_synced_out_reg;

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      cmp1_synced_out_reg <= 1'b0;
      cmp2_synced_out_reg <= 1'b0;
    end else if (tmr_rise) begin
      cmp1_synced_out_reg <= cmp1_lvl;
      cmp2_synced_out_reg <= cmp2_lvl;
    end
  end

  wire cmp1_synced_out;
  wire cmp2_synced_out;

  assign cmp1_synced_out = latch_ctrl_c_reg[`SRL_C_CMP1_SYNC] ?
                           cmp1_synced_out_reg : cmp1_lvl; // RULE5
  assign cmp2_synced_out = latch_ctrl_c_reg[`SRL_C_CMP2_SYNC] ?
                           cmp2_synced_out_reg : cmp2_lvl; // RULE5

  // ========================================================
  // periodic pulse
  wire div_pulse;

  srl_pulse_gen #(
    .CNT_W(`SRL_DIV_CNT_W)
  ) u_pulse (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .div_sel_in(periodic_pulse_divider_reg),
    .pulse_out(div_pulse)
  );

  // ========================================================
  // combined set and reset requests
  wire set_req;
  wire rst_req;

  // a source enabled on both sides simply resets; firmware must
  // not rely on it
  assign set_req = soft_set_pulse_reg // RULE2
    | (cmp1_synced_out & latch_ctrl_b_reg[`SRL_B_SET_CMP1])
    | (cmp2_synced_out & latch_ctrl_b_reg[`SRL_B_SET_CMP2])
    | (ext_lvl & latch_ctrl_b_reg[`SRL_B_SET_EXT])
    | (div_pulse & pulse_set_enable); // RULE7 RULE8
  assign rst_req = soft_reset_pulse_reg // RULE2
    | (cmp1_synced_out & latch_ctrl_b_reg[`SRL_B_RST_CMP1])
    | (cmp2_synced_out & latch_ctrl_b_reg[`SRL_B_RST_CMP2])
    | (ext_lvl & latch_ctrl_b_reg[`SRL_B_RST_EXT])
    | (div_pulse & pulse_reset_enable); // RULE7

  // ========================================================
  // the latch; deliberately not reset, firmware must set it
  // sys_clk stand-in for a clockless latch: one cycle of delay
  reg latch_q_reg;
  reg latch_q_next;

  always @* begin
    latch_q_next = latch_q_reg; // RULE1
    if (latch_enable_reg) begin // RULE13
      if (rst_req) begin
        latch_q_next = 1'b0; // RULE3
      end else if (set_req) begin
        latch_q_next = 1'b1; // RULE1
      end
    end
  end

  always @(posedge sys_clk_in) begin
    latch_q_reg <= latch_q_next; // RULE11
  end

  // ========================================================
  // pins: enables gated by latch enable, value zero when off
  reg true_oe_next;
  reg inv_oe_next;
  reg true_pin_next;
  reg inv_pin_next;

  always @* begin
    true_oe_next = latch_enable_reg & true_out_enable_reg; // RULE9
    inv_oe_next = latch_enable_reg & inverted_out_enable_reg; // RULE9 RULE13
    true_pin_next = true_oe_next & latch_q_reg;
    inv_pin_next = inv_oe_next & ~latch_q_reg;
  end

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      true_out_pin_out <= 1'b0;
      true_out_oe_out <= 1'b0;
      inverted_out_pin_out <= 1'b0;
      inverted_out_oe_out <= 1'b0;
    end else begin
      true_out_pin_out <= true_pin_next;
      true_out_oe_out <= true_oe_next;
      inverted_out_pin_out <= inv_pin_next;
      inverted_out_oe_out <= inv_oe_next;
    end
  end

  // ========================================================
  // avalon-mm slave: one wait cycle, then the handshake edge
  wire req;
  wire wr_take;
  wire lane0;

  assign req = avs_read_in | avs_write_in;
  // a write lands at the edge where waitrequest is seen low
  assign wr_take = avs_write_in & ~avs_waitrequest_out;
  assign lane0 = avs_byteenable_in[0];

  function [31:0] read_mux;
    input [3:0] addr;
    input [7:0] a_val;
    input [7:0] b_val;
    input [1:0] c_val;
    input [3:0] s_val;
    begin
      case (addr)
        `SRL_OFS_CTRL_A: read_mux = {24'h00_0000, a_val};
        `SRL_OFS_CTRL_B: read_mux = {24'h00_0000, b_val};
        `SRL_OFS_CTRL_C: read_mux = {30'h0000_0000, c_val};
        `SRL_OFS_STATUS: read_mux = {28'h000_0000, s_val};
        default: read_mux = 32'h0000_0000;
      endcase
    end
  endfunction

  reg [7:0] ctrl_a_view;
  reg [3:0] status_view;

  // soft bits always read back as zero
  always @* begin
    ctrl_a_view = 8'h00; // RULE14
    ctrl_a_view[`SRL_A_LATCH_EN] = latch_enable_reg;
    ctrl_a_view[`SRL_A_DIV_HI:`SRL_A_DIV_LO] = periodic_pulse_divider_reg;
    ctrl_a_view[`SRL_A_TRUE_OE] = true_out_enable_reg;
    ctrl_a_view[`SRL_A_INV_OE] = inverted_out_enable_reg;
  end

  always @* begin
    status_view = 4'h0;
    status_view[`SRL_S_LATCH_Q] = latch_q_reg;
    status_view[`SRL_S_CMP1] = cmp1_synced_out;
    status_view[`SRL_S_CMP2] = cmp2_synced_out;
    status_view[`SRL_S_EXT] = ext_lvl;
  end

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
    end else if (req & avs_waitrequest_out) begin
      avs_waitrequest_out <= 1'b0;
      avs_readdata_out <= read_mux(avs_address_in, ctrl_a_view,
                                   latch_ctrl_b_reg, latch_ctrl_c_reg,
                                   status_view);
    end else begin
      avs_waitrequest_out <= 1'b1;
    end
  end

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      latch_enable_reg <= ctrl_a_rst[`SRL_A_LATCH_EN];
      periodic_pulse_divider_reg <=
        ctrl_a_rst[`SRL_A_DIV_HI:`SRL_A_DIV_LO];
      true_out_enable_reg <= ctrl_a_rst[`SRL_A_TRUE_OE];
      inverted_out_enable_reg <= ctrl_a_rst[`SRL_A_INV_OE];
      latch_ctrl_b_reg <= `SRL_RST_CTRL_B;
      latch_ctrl_c_reg <= `SRL_RST_CTRL_C;
      soft_set_pulse_reg <= 1'b0;
      soft_reset_pulse_reg <= 1'b0;
    end else begin
      // self clearing: high for exactly one cycle per write
      soft_set_pulse_reg <= 1'b0; // RULE4
      soft_reset_pulse_reg <= 1'b0; // RULE4
      if (wr_take & lane0) begin
        case (avs_address_in)
          `SRL_OFS_CTRL_A: begin
            latch_enable_reg <= avs_writedata_in[`SRL_A_LATCH_EN];
            periodic_pulse_divider_reg <=
              avs_writedata_in[`SRL_A_DIV_HI:`SRL_A_DIV_LO]; // RULE6
            true_out_enable_reg <= avs_writedata_in[`SRL_A_TRUE_OE];
            inverted_out_enable_reg <= avs_writedata_in[`SRL_A_INV_OE];
            soft_set_pulse_reg <=
              avs_writedata_in[`SRL_A_SOFT_SET]; // RULE14
            soft_reset_pulse_reg <=
              avs_writedata_in[`SRL_A_SOFT_RST]; // RULE14
          end
          `SRL_OFS_CTRL_B: begin
            latch_ctrl_b_reg <= avs_writedata_in[7:0];
          end
          `SRL_OFS_CTRL_C: begin
            latch_ctrl_c_reg <= avs_writedata_in[1:0];
          end
          default: begin
            latch_ctrl_c_reg <= latch_ctrl_c_reg;
          end
        endcase
      end
    end
  end

endmodule // srl_latch_top

// File: rtl/srl_pulse_gen.v
`timescale 1ns/1ps
`include "srl_regs.vh"

module srl_pulse_gen #(
  parameter CNT_W = `SRL_DIV_CNT_W
) (
  input wire sys_clk_in,
  input wire rst_in,
  input wire [2:0] div_sel_in,
  output reg pulse_out
);

  // ========================================================
  // free-running divider
  reg [CNT_W-1:0] cnt_reg;
  wire [3:0] span;
  wire [CNT_W-1:0] low_mask;

  assign span = {1'b0, div_sel_in} + 4'd`SRL_DIV_LOG2_MIN;
  assign low_mask = ~({CNT_W{1'b1}} << span);

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      cnt_reg <= {CNT_W{1'b0}};
      pulse_out <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1; // RULE15
      // one cycle high each time the selected bit falls, as the low bits wrap to zero
      pulse_out <= ((cnt_reg & low_mask) == low_mask); // RULE6 RULE12
    end
  end

endmodule // srl_pulse_gen

// File: rtl/srl_regs.vh
`ifndef SRL_REGS_VH
`define SRL_REGS_VH

// ==========================================================
// register byte offsets
`define SRL_OFS_CTRL_A 4'h0
`define SRL_OFS_CTRL_B 4'h4
`define SRL_OFS_CTRL_C 4'h8
`define SRL_OFS_STATUS 4'hc

// ==========================================================
// latch_ctrl_a fields
`define SRL_A_LATCH_EN 7
`define SRL_A_DIV_HI 6
`define SRL_A_DIV_LO 4
`define SRL_A_TRUE_OE 3
`define SRL_A_INV_OE 2
`define SRL_A_SOFT_SET 1
`define SRL_A_SOFT_RST 0

// ==========================================================
// latch_ctrl_b fields: set sources high nibble, reset low
`define SRL_B_SET_EXT 7
`define SRL_B_SET_PULSE 6
`define SRL_B_SET_CMP2 5
`define SRL_B_SET_CMP1 4
`define SRL_B_RST_EXT 3
`define SRL_B_RST_PULSE 2
`define SRL_B_RST_CMP2 1
`define SRL_B_RST_CMP1 0

// ==========================================================
// latch_ctrl_c fields
`define SRL_C_CMP1_SYNC 0
`define SRL_C_CMP2_SYNC 1

// ==========================================================
// status fields
`define SRL_S_LATCH_Q 0
`define SRL_S_CMP1 1
`define SRL_S_CMP2 2
`define SRL_S_EXT 3

// ==========================================================
// reset values
`define SRL_RST_CTRL_A 8'h00
`define SRL_RST_CTRL_B 8'h00
`define SRL_RST_CTRL_C 2'h0

// ==========================================================
// divider: shortest period is 2^DIV_LOG2_MIN cycles
`define SRL_DIV_LOG2_MIN 2
`define SRL_DIV_CNT_W 9

`endif

// File: tb/srl_latch_sva.sv
`timescale 1ns/1ps
module srl_latch_sva (
  input wire sys_clk_in,
  input wire rst_in,
  input wire [3:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_readdata_out,
  input wire avs_waitrequest_out,
  input wire true_out_pin_out,
  input wire true_out_oe_out,
  input wire inverted_out_pin_out,
  input wire inverted_out_oe_out
);
  wire wr_taken = avs_write_in && !avs_waitrequest_out;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // ==========================================================
  // bus steps
  sequence s_req;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_rd;
    avs_read_in && !avs_waitrequest_out;
  endsequence
  a_wait_answer: assert property (s_req |=> !avs_waitrequest_out)
    else $error("no answer one cycle after request");
  a_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("wait low longer than one cycle");
  a_wait_cause: assert property (!avs_waitrequest_out |->
    $past(avs_read_in || avs_write_in)) else $error("answer without request");
  a_soft_read0: assert property (s_rd ##0 avs_address_in == 4'h0 |->
    avs_readdata_out[1:0] == 2'b00) else $error("soft bits read one");
  a_upper_zero: assert property (s_rd |-> avs_readdata_out[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_unmapped_zero: assert property (s_rd ##0 avs_address_in[1:0] != 2'b00 |->
    avs_readdata_out == 32'h0000_0000) else $error("unmapped read not zero");
  // ==========================================================
  // pins
  a_true_off: assert property (!true_out_oe_out |-> !true_out_pin_out)
    else $error("true pin high while not driven");
  a_inv_off: assert property (!inverted_out_oe_out |-> !inverted_out_pin_out)
    else $error("inverted pin high while not driven");
  a_pins_compl: assert property (true_out_oe_out && inverted_out_oe_out |->
    true_out_pin_out != inverted_out_pin_out) else $error("pins not complementary");
  a_oe_cause: assert property ($changed(true_out_oe_out) |->
    $past(wr_taken, 1) || $past(wr_taken, 2) || $past(wr_taken, 3))
    else $error("output enable changed without write");
endmodule // srl_latch_sva

bind srl_latch_top srl_latch_sva u_srl_latch_sva (.sys_clk_in(sys_clk_in),
  .rst_in(rst_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out),
  .true_out_pin_out(true_out_pin_out), .true_out_oe_out(true_out_oe_out),
  .inverted_out_pin_out(inverted_out_pin_out),
  .inverted_out_oe_out(inverted_out_oe_out));

// File: tb/srl_latch_top_bench.sv
`timescale 1ns/1ps
module srl_latch_top_bench;
  logic sys_clk_in = 0, rst_in = 1, avs_read_in = 0, avs_write_in = 0;
  logic [3:0] avs_address_in = 0, avs_byteenable_in = 4'h1;
  logic [31:0] avs_writedata_in = 0;
  logic [2:0] drive = 0;
  logic pin_direction_bit = 1'b1;
  logic [7:0] rd;
  wire [31:0] avs_readdata_out;
  wire avs_waitrequest_out, true_out_pin_out, true_out_oe_out;
  wire inverted_out_pin_out, inverted_out_oe_out, cmp1, cmp2, ext, tclk;
  int errors = 0, tests_run = 0, cyc = 0, t1, tr, t2, n;
  // one source never on both inputs
  logic [7:0] setm [3] = '{8'h10, 8'h20, 8'h80};
  logic [7:0] rstm [3] = '{8'h01, 8'h02, 8'h08};
  initial forever #10 sys_clk_in = ~sys_clk_in;
  srl_src_model u_srl_src_model (.drive_in(drive), .cmp1_out(cmp1),
    .cmp2_out(cmp2), .ext_out(ext), .timer_clk_out(tclk));
  srl_latch_top u_srl_latch_top (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .cmp1_in(cmp1),
    .cmp2_in(cmp2), .ext_latch_input_in(ext), .timer_clk_in(tclk),
    .true_out_pin_out(true_out_pin_out), .true_out_oe_out(true_out_oe_out),
    .inverted_out_pin_out(inverted_out_pin_out),
    .inverted_out_oe_out(inverted_out_oe_out));
  // ==========================================================
  // tasks
  task end_of_test;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task av(input logic [3:0] a, input logic w, input logic [7:0] d,
    input logic [3:0] be);
    @(posedge sys_clk_in);
    avs_address_in <= a;
    avs_write_in <= w;
    avs_read_in <= !w;
    avs_writedata_in <= {24'h00_0000, d};
    avs_byteenable_in <= be;
    do @(posedge sys_clk_in); while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out[7:0];
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    av(a, 1'b1, d, 4'h1);
  endtask
  task rdc(input string nm, input logic [3:0] a, input logic [7:0] e);
    av(a, 1'b0, 8'h00, 4'h1);
    chk(nm, rd, e);
  endtask
  task pin_wait(input logic v);
    do @(posedge sys_clk_in); while (true_out_pin_out !== v);
  endtask
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      end_of_test;
    end
  end
  // ==========================================================
  // sequence
  initial begin
    repeat (4) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    rdc("ctrl_a", 4'h0, 8'h00);
    rdc("ctrl_b", 4'h4, 8'h00);
    rdc("ctrl_c", 4'h8, 8'h00);
    rdc("unmapped", 4'h2, 8'h00);
    av(4'h8, 1'b1, 8'h03, 4'h0);
    rdc("lane_off", 4'h8, 8'h00);
    // latch put in a known state before pins enabled
    wr(4'h0, 8'h81);
    rdc("soft_rd0", 4'h0, 8'h80);
    rdc("q_reset", 4'hc, 8'h00);
    wr(4'h0, 8'h82);
    rdc("q_set", 4'hc, 8'h01);
    wr(4'h0, 8'h83);
    rdc("q_both", 4'hc, 8'h00);
    wr(4'h0, 8'h82);
    wr(4'h0, 8'h01);
    rdc("q_disabled", 4'hc, 8'h01);
    pin_direction_bit <= 1'b0;
    wr(4'h0, 8'h8c);
    repeat (3) @(posedge sys_clk_in);
    chk("pins_on", {true_out_oe_out & !pin_direction_bit, true_out_pin_out,
      inverted_out_oe_out, inverted_out_pin_out}, 4'b1110);
    wr(4'h0, 8'h0c);
    repeat (3) @(posedge sys_clk_in);
    chk("pins_off", {true_out_oe_out, true_out_pin_out, inverted_out_oe_out,
      inverted_out_pin_out}, 4'b0000);
    for (int s = 0; s < 2; s++) begin
      wr(4'h8, s ? 8'h03 : 8'h00);
      for (int i = 0; i < 3; i++) begin
        wr(4'h0, 8'h81);
        wr(4'h4, setm[i]);
        drive[i] <= 1'b1;
        repeat (16) @(posedge sys_clk_in);
        drive[i] <= 1'b0;
        rdc("src_set", 4'hc, 8'(8'h02 << i) | 8'h01);
        repeat (16) @(posedge sys_clk_in);
        rdc("src_hold", 4'hc, 8'h01);
        wr(4'h4, rstm[i]);
        drive[i] <= 1'b1;
        repeat (16) @(posedge sys_clk_in);
        rdc("src_reset", 4'hc, 8'(8'h02 << i));
        drive[i] <= 1'b0;
      end
    end
    // ext holds set; periodic reset shows as one-cycle dip
    drive <= 3'b100;
    wr(4'h4, 8'h84);
    for (int sel = 0; sel < 8; sel++) begin
      wr(4'h0, {1'b1, 3'(sel), 4'h8});
      pin_wait(1'b0);
      pin_wait(1'b1);
      pin_wait(1'b0);
      t1 = cyc;
      pin_wait(1'b1);
      tr = cyc;
      pin_wait(1'b0);
      t2 = cyc;
      chk("pulse_width", tr - t1, 1);
      chk("pulse_period", t2 - t1, 4 << sel);
    end
    wr(4'h0, 8'h88);
    wr(4'h4, 8'h80);
    repeat (4) @(posedge sys_clk_in);
    n = 0;
    repeat (40) begin
      @(posedge sys_clk_in);
      if (true_out_pin_out !== 1'b1) n++;
    end
    chk("pulse_gated", n, 0);
    end_of_test;
  end
endmodule // srl_latch_top_bench

// File: tb/srl_src_model.sv
`timescale 1ns/1ps
module srl_src_model (
  input wire [2:0] drive_in,
  output logic cmp1_out,
  output logic cmp2_out,
  output logic ext_out,
  output logic timer_clk_out
);
  assign cmp1_out = drive_in[0];
  assign cmp2_out = drive_in[1];
  assign ext_out = drive_in[2];
  // free-running, phase unrelated to the system clock
  initial begin
    timer_clk_out = 1'b0;
    forever #35 timer_clk_out = ~timer_clk_out;
  end
endmodule // srl_src_model
